// file: rtl/monitor_pins_defs.svh
// constants for the host-side control pins of the monitor device
`ifndef MONITOR_PINS_DEFS_SVH
`define MONITOR_PINS_DEFS_SVH
// ****************************************
// timing
// ****************************************
`define MCLK_PERIOD_NS 25
`define DAV_PULSE_NS 1000
`define DAV_PULSE_CYCLES ((`DAV_PULSE_NS + `MCLK_PERIOD_NS - 1) / `MCLK_PERIOD_NS)
// ****************************************
// i2c framing and gpio count
// ****************************************
`define I2C_ADDR_HI_DEFAULT 4'h6
`define BITS_PER_BYTE 4'h8
`define GPIO_COUNT_DEFAULT 4
`endif

// file: rtl/monitor_pins_pkg.sv
// types for the host-side control pins of the monitor device
package monitor_pins_pkg;
  typedef enum logic [2:0] {
    I_IDLE,
    I_ADDR,
    I_ACK,
    I_WDATA,
    I_RDATA,
    I_RACK,
    I_IGNORE
  } i2c_state_t;
endpackage

// file: rtl/sync_stage.sv
// two-flop synchroniser for a vector of pin inputs
`timescale 1ns/1ps
`default_nettype none
module sync_stage #(
  parameter int W = 8
) (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic [W-1:0] pinIn,
  output logic [W-1:0] pinSync
);
  typedef struct packed {
    logic [W-1:0] first;
    logic [W-1:0] second;
  } sync_t;

  sync_t st;
  sync_t next_st;

  generate
    if (W < 1) begin : g_chk
      $error("sync_stage width must be at least one");
    end
  endgenerate

  // idle pins sit high, so reset to ones to avoid false edges
  always_comb begin
    if (sys_rst) begin
      next_st = '1;
    end else begin
      next_st.first = pinIn;
      next_st.second = st.first;
    end
  end

  always_ff @(posedge mclk) begin
    st <= next_st;
  end

  assign pinSync = st.second;
endmodule // sync_stage
`default_nettype wire

// file: rtl/monitor_host_control_pins.sv
// host-facing control pins: reset, trigger, data-available, serial port, gpio
`timescale 1ns/1ps
`default_nettype none
`include "monitor_pins_defs.svh"
module monitor_host_control_pins
  import monitor_pins_pkg::*;
#(
  parameter int GPIO_COUNT = `GPIO_COUNT_DEFAULT,
  parameter logic [3:0] I2C_ADDR_HI = `I2C_ADDR_HI_DEFAULT
) (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic resetPinN,
  input wire logic ext_conv_trigger_n,
  output logic data_avail_n,
  input wire logic autoMode,
  input wire logic convDone,
  input wire logic cycleDone,
  input wire logic davClear,
  output logic convStart,
  output logic coreReset,
  input wire logic ifaceSelStrap,
  output logic spiSelected,
  output logic i2cSelected,
  input wire logic serialClk,
  input wire logic shared_serial_data_in,
  output logic shared_serial_data_out,
  output logic shared_serial_data_oe_n,
  input wire logic select_or_addr_bit0,
  input wire logic serial_out_or_addr_bit1_in,
  output logic serial_out_or_addr_bit1_out,
  output logic serial_out_or_addr_bit1_oe_n,
  input wire logic i2c_addr_bit2,
  output logic [7:0] rxData,
  output logic rxValid,
  input wire logic [7:0] txData,
  output logic txTaken,
  input wire logic [GPIO_COUNT-1:0] gpioIn,
  output logic [GPIO_COUNT-1:0] gpioOut,
  output logic [GPIO_COUNT-1:0] gpioOe_n,
  input wire logic [GPIO_COUNT-1:0] gpioPullLow,
  output logic [GPIO_COUNT-1:0] gpioLevel
);
  localparam int SW = GPIO_COUNT + 8;
  localparam logic [5:0] DAV_CYCLES = 6'(`DAV_PULSE_CYCLES);

  generate
    if (GPIO_COUNT < 1 || `DAV_PULSE_CYCLES > 63) begin : g_chk
      $error("unsupported gpio count or pulse length");
    end
  endgenerate

  typedef struct packed {
    logic strapDone;
    logic [1:0] strapWait;
    logic spiSel;
    logic coreRst;
    logic sclPrev;
    logic sdaPrev;
    logic csPrev;
    logic convPrev;
    logic convStart;
    logic davN;
    logic [5:0] davCnt;
    i2c_state_t ist;
    logic [3:0] bitCnt;
    logic [7:0] rxSh;
    logic [7:0] txSh;
    logic rw;
    logic nack;
    logic [7:0] rxData;
    logic rxValid;
    logic txTaken;
    logic sdaOe_n;
    logic sdoBit;
    logic sdoOe_n;
    logic [GPIO_COUNT-1:0] gpioOut;
    logic [GPIO_COUNT-1:0] gpioOe_n;
    logic [GPIO_COUNT-1:0] gpioLevel;
  } state_t;

  state_t st;
  state_t next_st;
  logic [SW-1:0] pinSync;

  // ****************************************
  // pin synchronisers
  // ****************************************
  sync_stage #(.W(SW)) u_sync (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .pinIn({gpioIn, ifaceSelStrap, i2c_addr_bit2, serial_out_or_addr_bit1_in,
            select_or_addr_bit0, shared_serial_data_in, serialClk, ext_conv_trigger_n,
            resetPinN}),
    .pinSync(pinSync)
  );

  logic rstPinS, convS, sclS, sdaS, csS, a1S, a2S, strapS;
  logic [GPIO_COUNT-1:0] gpioS;
  assign {gpioS, strapS, a2S, a1S, csS, sdaS, sclS, convS, rstPinS} = pinSync;

  function automatic logic addrHit(input logic [6:0] a, input logic [3:0] hi,
                                   input logic b2, input logic b1, input logic b0);
    addrHit = (a == {hi, b2, b1, b0});
  endfunction

  logic sclRise, sclFall, i2cStart, i2cStop;
  assign sclRise = sclS & ~st.sclPrev;
  assign sclFall = ~sclS & st.sclPrev;
  assign i2cStart = sclS & st.sclPrev & st.sdaPrev & ~sdaS;
  assign i2cStop = sclS & st.sclPrev & ~st.sdaPrev & sdaS;

  // ****************************************
  // next-state logic
  // ****************************************
  always_comb begin
    next_st = st;
    next_st.convStart = 1'b0;
    next_st.rxValid = 1'b0;
    next_st.txTaken = 1'b0;
    if (sys_rst || !rstPinS) begin
      next_st = '0;
      next_st.coreRst = 1'b1;
      next_st.sclPrev = 1'b1;
      next_st.sdaPrev = 1'b1;
      next_st.csPrev = 1'b1;
      next_st.convPrev = 1'b1;
      next_st.davN = 1'b1;
      next_st.ist = I_IDLE;
      next_st.sdaOe_n = 1'b1;
      next_st.sdoOe_n = 1'b1;
      next_st.gpioOe_n = '1;
      next_st.gpioLevel = '1;
    end else begin
      next_st.coreRst = 1'b0;
      next_st.sclPrev = sclS;
      next_st.sdaPrev = sdaS;
      next_st.csPrev = csS;
      next_st.convPrev = convS;
      // strap held until the synchroniser has flushed its reset ones, then frozen
      if (!st.strapDone) begin
        next_st.strapWait = st.strapWait + 2'h1;
        next_st.strapDone = st.strapWait[1];
        next_st.spiSel = strapS;
      end
      next_st.convStart = st.convPrev & ~convS;

      // data-available indicator
      if (autoMode) begin
        if (cycleDone) begin
          next_st.davCnt = DAV_CYCLES;
          next_st.davN = 1'b0;
        end else if (st.davCnt > 6'h01) begin
          next_st.davCnt = st.davCnt - 6'h01;
        end else begin
          next_st.davCnt = 6'h00;
          next_st.davN = 1'b1;
        end
      end else begin
        next_st.davCnt = 6'h00;
        // completion wins over a clear in the same cycle
        if (convDone) begin
          next_st.davN = 1'b0;
        end else if (davClear || st.convStart) begin
          next_st.davN = 1'b1;
        end
      end

      // open-drain gpio: output data fixed low, enable only pulls
      next_st.gpioOut = '0;
      next_st.gpioOe_n = ~gpioPullLow;
      next_st.gpioLevel = gpioS;

      // ****************************************
      // spi port
      // ****************************************
      if (st.strapDone && st.spiSel) begin
        next_st.sdaOe_n = 1'b1;
        next_st.ist = I_IDLE;
        if (csS) begin
          next_st.sdoOe_n = 1'b1;
          next_st.bitCnt = 4'h0;
        end else begin
          next_st.sdoOe_n = 1'b0;
          if (st.csPrev) begin
            next_st.txSh = txData;
            next_st.sdoBit = txData[7];
            next_st.txTaken = 1'b1;
            next_st.bitCnt = 4'h0;
          end else if (sclRise) begin
            next_st.rxSh = {st.rxSh[6:0], sdaS};
            next_st.bitCnt = {1'b0, 3'(st.bitCnt[2:0] + 3'h1)};
            if (st.bitCnt[2:0] == 3'h7) begin
              next_st.rxData = {st.rxSh[6:0], sdaS};
              next_st.rxValid = 1'b1;
            end
          end else if (sclFall) begin
            if (st.bitCnt[2:0] == 3'h0) begin
              next_st.txSh = txData;
              next_st.sdoBit = txData[7];
              next_st.txTaken = 1'b1;
            end else begin
              next_st.txSh = {st.txSh[6:0], 1'b0};
              next_st.sdoBit = st.txSh[6];
            end
          end
        end
      end else if (st.strapDone) begin
        // ****************************************
        // i2c port, address pins only read here
        // ****************************************
        next_st.sdoOe_n = 1'b1;
        if (i2cStart) begin
          next_st.ist = I_ADDR;
          next_st.bitCnt = 4'h0;
          next_st.sdaOe_n = 1'b1;
        end else if (i2cStop) begin
          next_st.ist = I_IDLE;
          next_st.sdaOe_n = 1'b1;
        end else begin
          case (st.ist)
            I_ADDR, I_WDATA: begin
              if (sclRise) begin
                next_st.rxSh = {st.rxSh[6:0], sdaS};
                next_st.bitCnt = st.bitCnt + 4'h1;
              end else if (sclFall && st.bitCnt == `BITS_PER_BYTE) begin
                next_st.bitCnt = 4'h0;
                if (st.ist == I_WDATA) begin
                  next_st.rxData = st.rxSh;
                  next_st.rxValid = 1'b1;
                  next_st.ist = I_ACK;
                  next_st.sdaOe_n = 1'b0;
                end else if (addrHit(st.rxSh[7:1], I2C_ADDR_HI, a2S, a1S, csS)) begin
                  next_st.rw = st.rxSh[0];
                  next_st.ist = I_ACK;
                  next_st.sdaOe_n = 1'b0;
                end else begin
                  next_st.ist = I_IGNORE;
                end
              end
            end
            I_ACK: begin
              if (sclFall) begin
                if (st.rw) begin
                  next_st.txSh = txData;
                  next_st.txTaken = 1'b1;
                  next_st.sdaOe_n = txData[7];
                  next_st.ist = I_RDATA;
                end else begin
                  next_st.sdaOe_n = 1'b1;
                  next_st.ist = I_WDATA;
                end
              end
            end
            I_RDATA: begin
              if (sclFall) begin
                next_st.bitCnt = st.bitCnt + 4'h1;
                next_st.txSh = {st.txSh[6:0], 1'b0};
                if (st.bitCnt == 4'h7) begin
                  next_st.sdaOe_n = 1'b1;
                  next_st.bitCnt = 4'h0;
                  next_st.ist = I_RACK;
                end else begin
                  next_st.sdaOe_n = st.txSh[6];
                end
              end
            end
            I_RACK: begin
              if (sclRise) begin
                next_st.nack = sdaS;
              end else if (sclFall) begin
                if (st.nack) begin
                  next_st.ist = I_IGNORE;
                end else begin
                  next_st.txSh = txData;
                  next_st.txTaken = 1'b1;
                  next_st.sdaOe_n = txData[7];
                  next_st.ist = I_RDATA;
                end
              end
            end
            default: begin
              next_st.sdaOe_n = 1'b1;
            end
          endcase
        end
      end
    end
  end

  always_ff @(posedge mclk) begin
    st <= next_st;
  end

  // ****************************************
  // outputs, all registered except the constant-low shared_serial_data_out and the two port selects, each an AND of two flops
  // ****************************************
  assign data_avail_n = st.davN;
  assign convStart = st.convStart;
  assign coreReset = st.coreRst;
  assign spiSelected = st.strapDone & st.spiSel;
  assign i2cSelected = st.strapDone & ~st.spiSel;
  assign shared_serial_data_out = 1'b0;
  assign shared_serial_data_oe_n = st.sdaOe_n;
  assign serial_out_or_addr_bit1_out = st.sdoBit;
  assign serial_out_or_addr_bit1_oe_n = st.sdoOe_n;
  assign rxData = st.rxData;
  assign rxValid = st.rxValid;
  assign txTaken = st.txTaken;
  assign gpioOut = st.gpioOut;
  assign gpioOe_n = st.gpioOe_n;
  assign gpioLevel = st.gpioLevel;
endmodule // monitor_host_control_pins
`default_nettype wire

// file: dv/host_model.sv
// host master model: conversion trigger, serial clock, chip select, data line
`timescale 1ns/1ps
`default_nettype none
module host_model (
  input wire logic mclk,
  input wire logic dataLine,
  input wire logic sdoLine,
  output logic trigN,
  output logic sclk,
  output logic csN,
  output logic dOut
);
  initial begin
    trigN = 1'b1;
    sclk = 1'b0;
    csN = 1'b1;
    dOut = 1'b1;
  end
  task automatic hop(input int n);
    repeat (n) @(negedge mclk);
  endtask
  task automatic trigger();
    trigN = 1'b0;
    hop(8);
    trigN = 1'b1;
  endtask
  // clock idles low outside the frame; half period of 4 mclk gives a 200 ns clock period
  task automatic spi_byte(input logic [7:0] tx, output logic [7:0] rx);
    csN = 1'b0;
    hop(4);
    for (int i = 7; i >= 0; i--) begin
      dOut = tx[i];
      hop(4);
      sclk = 1'b1;
      rx[i] = sdoLine;
      hop(4);
      sclk = 1'b0;
    end
    hop(8);
    csN = 1'b1;
    dOut = ~dOut;
  endtask
  // data moves one mclk after the clock falls so it is never read as start or stop
  task automatic i2c_frame(input logic [7:0] adr, input logic [7:0] dat, output logic [1:0] ack);
    sclk = 1'b1;
    hop(8);
    dOut = 1'b0;
    hop(4);
    for (int i = 17; i >= 0; i--) begin
      sclk = 1'b0;
      hop(1);
      dOut = (i == 9 || i == 0) ? 1'b1 : (i > 9 ? adr[i-10] : dat[i-1]);
      hop(3);
      sclk = 1'b1;
      hop(4);
      if (i == 9) ack[1] = !dataLine;
      if (i == 0) ack[0] = !dataLine;
    end
    sclk = 1'b0;
    hop(1);
    dOut = 1'b0;
    hop(3);
    sclk = 1'b1;
    hop(4);
    dOut = 1'b1;
    hop(4);
  endtask
endmodule // host_model
`default_nettype wire

// file: dv/monitor_pins_chk.sv
// assertions on the host control pins
`timescale 1ns/1ps
`default_nettype none
`include "monitor_pins_defs.svh"
module monitor_pins_chk #(
  parameter int GPIO_COUNT = 4
) (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic resetPinN,
  input wire logic ext_conv_trigger_n,
  input wire logic data_avail_n,
  input wire logic autoMode,
  input wire logic convDone,
  input wire logic cycleDone,
  input wire logic davClear,
  input wire logic convStart,
  input wire logic coreReset,
  input wire logic spiSelected,
  input wire logic i2cSelected,
  input wire logic shared_serial_data_out,
  input wire logic shared_serial_data_oe_n,
  input wire logic select_or_addr_bit0,
  input wire logic serial_out_or_addr_bit1_oe_n,
  input wire logic [GPIO_COUNT-1:0] gpioOut
);
  default clocking @(posedge mclk); endclocking
  default disable iff (sys_rst);
  // a retrigger restarts the count, so pulse width is tracked here
  logic [6:0] lowCnt;
  always_ff @(posedge mclk) begin
    if (sys_rst || !autoMode) lowCnt <= 7'h00;
    else if (cycleDone) lowCnt <= 7'h01;
    else if (lowCnt != 7'h00 && lowCnt != 7'(`DAV_PULSE_CYCLES)) lowCnt <= lowCnt + 7'h01;
    else lowCnt <= 7'h00;
  end
  sequence trigHeld;
    $fell(ext_conv_trigger_n) ##1 !ext_conv_trigger_n [*2];
  endsequence
  sequence csIdle;
    (spiSelected && select_or_addr_bit0) [*4];
  endsequence
  a_trig_starts: assert property (trigHeld |-> ##[0:1] convStart)
    else $error("no conversion start after trigger");
  a_start_single: assert property (convStart |=> !convStart)
    else $error("conversion start longer than one cycle");
  a_direct_set: assert property (!autoMode && convDone |=> !data_avail_n)
    else $error("data available not set");
  a_direct_clear: assert property (!autoMode && davClear && !convDone |=> data_avail_n)
    else $error("data available not cleared");
  a_auto_width: assert property (autoMode && !coreReset |-> data_avail_n == (lowCnt == 7'h00))
    else $error("auto pulse width wrong");
  a_iface_excl: assert property (!(spiSelected && i2cSelected))
    else $error("both ports selected");
  a_spi_data_in: assert property (!shared_serial_data_out && (!spiSelected || shared_serial_data_oe_n))
    else $error("data pin driven wrongly");
  a_i2c_no_sdo: assert property (i2cSelected |-> serial_out_or_addr_bit1_oe_n)
    else $error("output pin driven under i2c");
  a_cs_release: assert property (csIdle |-> serial_out_or_addr_bit1_oe_n)
    else $error("output driven while deselected");
  a_pin_reset: assert property (!resetPinN [*5] |-> coreReset && data_avail_n && !convStart)
    else $error("reset pin not acting");
  a_gpio_drain: assert property (gpioOut == '0)
    else $error("gpio driven high");
endmodule // monitor_pins_chk
bind monitor_host_control_pins monitor_pins_chk #(.GPIO_COUNT(GPIO_COUNT)) chk_u (.mclk, .sys_rst,
  .resetPinN, .ext_conv_trigger_n, .data_avail_n, .autoMode, .convDone, .cycleDone, .davClear,
  .convStart, .coreReset, .spiSelected, .i2cSelected, .shared_serial_data_out,
  .shared_serial_data_oe_n, .select_or_addr_bit0, .serial_out_or_addr_bit1_oe_n, .gpioOut);
`default_nettype wire

// file: dv/tb.sv
// self-checking bench for the host control pins
`timescale 1ns/1ps
`default_nettype none
`include "monitor_pins_defs.svh"
module tb;
  logic mclk = 1'b0;
  logic sys_rst = 1'b1;
  logic resetPinN = 1'b1;
  logic autoMode = 1'b0;
  logic convDone = 1'b0;
  logic cycleDone = 1'b0;
  logic davClear = 1'b0;
  logic ifaceSelStrap = 1'b1;
  logic a0 = 1'b0;
  logic a1 = 1'b0;
  logic i2c_addr_bit2 = 1'b0;
  logic [7:0] txData = 8'h00;
  logic [3:0] gpioPullLow = 4'h0;
  logic [3:0] gpioExt = 4'h0;
  logic [7:0] lastRx = 8'h00;
  int error_cnt = 0;
  int cmp_count = 0;
  int cycles = 0;
  int takenCnt = 0;
  logic ext_conv_trigger_n, serialClk, csN, dOut, data_avail_n, convStart, coreReset;
  logic spiSelected, i2cSelected, rxValid, txTaken, shared_serial_data_out;
  logic shared_serial_data_oe_n, serial_out_or_addr_bit1_out, serial_out_or_addr_bit1_oe_n;
  logic [7:0] rxData;
  logic [3:0] gpioOut, gpioOe_n, gpioLevel;
  // pull-ups on the data line and gpio; released output pin falls back to its strap
  wire logic shared_serial_data_in = dOut & shared_serial_data_oe_n;
  wire logic select_or_addr_bit0 = ifaceSelStrap ? csN : a0;
  wire logic serial_out_or_addr_bit1_in = serial_out_or_addr_bit1_oe_n ? a1 :
    serial_out_or_addr_bit1_out;
  wire logic [3:0] gpioIn = (gpioOe_n | gpioOut) & ~gpioExt;
  monitor_host_control_pins dut_u (.mclk, .sys_rst, .resetPinN, .ext_conv_trigger_n,
    .data_avail_n, .autoMode, .convDone, .cycleDone, .davClear, .convStart, .coreReset,
    .ifaceSelStrap, .spiSelected, .i2cSelected, .serialClk, .shared_serial_data_in,
    .shared_serial_data_out, .shared_serial_data_oe_n, .select_or_addr_bit0,
    .serial_out_or_addr_bit1_in, .serial_out_or_addr_bit1_out, .serial_out_or_addr_bit1_oe_n,
    .i2c_addr_bit2, .rxData, .rxValid, .txData, .txTaken, .gpioIn, .gpioOut, .gpioOe_n,
    .gpioPullLow, .gpioLevel);
  host_model host_u (.mclk, .dataLine(shared_serial_data_in), .sdoLine(serial_out_or_addr_bit1_in),
    .trigN(ext_conv_trigger_n), .sclk(serialClk), .csN, .dOut);
  initial begin
    forever #12.5 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    if (rxValid === 1'b1) lastRx <= rxData;
    if (txTaken === 1'b1) takenCnt++;
    cycles++;
    if (cycles == 5000) begin
      error_cnt++;
      stop_test();
    end
  end
  task automatic hop(input int n);
    repeat (n) @(negedge mclk);
  endtask
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic stop_test();
    $display("comparisons %0d errors %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic t_trigger();
    int n;
    n = 0;
    fork
      host_u.trigger();
    join_none
    while (convStart !== 1'b1 && n < 10) begin
      @(posedge mclk);
      #1;
      n++;
    end
    chk("convLatency", 8'h03, 8'(n));
    hop(10);
  endtask
  task automatic t_direct();
    convDone = 1'b1;
    hop(1);
    convDone = 1'b0;
    hop(5);
    chk("davDirect", 8'h00, 8'(data_avail_n));
    davClear = 1'b1;
    hop(1);
    davClear = 1'b0;
    hop(1);
    chk("davCleared", 8'h01, 8'(data_avail_n));
  endtask
  task automatic t_auto();
    int n;
    n = 0;
    autoMode = 1'b1;
    cycleDone = 1'b1;
    hop(1);
    cycleDone = 1'b0;
    while (data_avail_n === 1'b0 && n < 200) begin
      cycleDone = (n == 20);
      hop(1);
      n++;
    end
    chk("davPulse", 8'(21 + `DAV_PULSE_CYCLES), 8'(n));
    autoMode = 1'b0;
  endtask
  task automatic t_gpio();
    gpioPullLow = 4'hA;
    gpioExt = 4'h1;
    hop(6);
    chk("gpioOe", 8'h05, 8'(gpioOe_n));
    chk("gpioLevel", 8'h04, 8'(gpioLevel));
    gpioPullLow = 4'h0;
    gpioExt = 4'h0;
  endtask
  task automatic t_pinreset();
    convDone = 1'b1;
    hop(1);
    convDone = 1'b0;
    resetPinN = 1'b0;
    hop(6);
    chk("coreReset", 8'h01, 8'(coreReset));
    chk("davReset", 8'h01, 8'(data_avail_n));
    resetPinN = 1'b1;
    hop(8);
  endtask
  task automatic t_spi();
    logic [7:0] rx;
    int t0;
    chk("spiSel", 8'h02, 8'({spiSelected, i2cSelected}));
    txData = 8'hA5;
    t0 = takenCnt;
    host_u.spi_byte(8'h3C, rx);
    chk("spiRead", 8'hA5, rx);
    chk("spiTaken", 8'h02, 8'(takenCnt - t0));
    chk("spiWrite", 8'h3C, lastRx);
  endtask
  task automatic t_i2c();
    logic [1:0] ack;
    ifaceSelStrap = 1'b0;
    sys_rst = 1'b1;
    hop(3);
    sys_rst = 1'b0;
    {i2c_addr_bit2, a1, a0} = 3'b101;
    hop(4);
    chk("i2cSel", 8'h01, 8'({spiSelected, i2cSelected}));
    host_u.i2c_frame({`I2C_ADDR_HI_DEFAULT, 3'b101, 1'b0}, 8'h5A, ack);
    chk("i2cAck", 8'h03, 8'(ack));
    chk("i2cWrite", 8'h5A, lastRx);
    host_u.i2c_frame({`I2C_ADDR_HI_DEFAULT, 3'b001, 1'b0}, 8'h66, ack);
    chk("i2cOther", 8'h00, 8'(ack));
  endtask
  initial begin
    hop(12);
    sys_rst = 1'b0;
    hop(4);
    t_trigger();
    t_direct();
    t_auto();
    t_gpio();
    t_pinreset();
    t_spi();
    t_i2c();
    stop_test();
  end
endmodule // tb
`default_nettype wire
